/* File: shared/dram_dll_pkg.sv */
// constants, field layouts and carrier types for the dram dll / write-leveling block
package dram_dll_pkg;

    // ****************************************
    // register map on the bus
    // ****************************************
    localparam logic [7:0]  ADDR_CTRL             = 8'h00;
    localparam logic [7:0]  ADDR_STATUS           = 8'h04;
    localparam logic [7:0]  ADDR_MODE0            = 8'h08;
    localparam logic [7:0]  ADDR_MODE1            = 8'h0c;
    localparam logic [7:0]  ADDR_MODE2            = 8'h10;
    localparam int          CTRL_FEEDBACK_EN_BIT  = 0;
    localparam int          CTRL_CLEAR_ERR_BIT    = 1;
    localparam logic        CTRL_FEEDBACK_EN_RST  = 1'b1;
    localparam int          STAT_DLL_OFF_BIT      = 0;
    localparam int          STAT_WL_MODE_BIT      = 1;
    localparam int          STAT_SR_BIT           = 2;
    localparam int          STAT_CLK_IGNORED_BIT  = 3;
    localparam int          STAT_PD_BIT           = 4;
    localparam int          STAT_LAT_ERR_BIT      = 5;
    localparam int          STAT_DLL_RESET_BIT    = 6;
    localparam int          STAT_LOWER_FB_BIT     = 7;
    localparam int          STAT_UPPER_FB_BIT     = 8;
    localparam int          STAT_LAUNCH_LSB       = 16;

    // ****************************************
    // mode register fields
    // ****************************************
    localparam logic [2:0]  BANK_MODE0            = 3'h0;
    localparam logic [2:0]  BANK_MODE1            = 3'h1;
    localparam logic [2:0]  BANK_MODE2            = 3'h2;
    localparam int          MR1_DLL_DISABLE_BIT   = 0;
    localparam int          MR1_WRITE_LEVEL_BIT   = 7;
    localparam int          MR0_DLL_RESET_BIT     = 8;
    localparam int          MR0_CL_LSB            = 4;
    localparam int          MR0_CL_MSB            = 6;
    localparam int          MR0_CL_EXT_BIT        = 2;
    localparam int          MR2_CWL_LSB           = 3;
    localparam int          MR2_CWL_MSB           = 5;
    localparam logic [2:0]  READ_LATENCY_6_CODE   = 3'h2;
    localparam logic [2:0]  WRITE_LATENCY_6_CODE  = 3'h1;
    localparam logic [4:0]  READ_LATENCY_OFFSET   = 5'h04;
    localparam logic [13:0] MODE_RST              = 14'h0000;

    // ****************************************
    // timing counts, in command-clock edges
    // ****************************************
    localparam logic [3:0]  CLOCK_HOLD_AFTER_SR_ENTRY = 4'h5;

    typedef enum logic [1:0] {
        ST_ACTIVE       = 2'b00,
        ST_SELF_REFRESH = 2'b01,
        ST_SR_CLK_FREE  = 2'b10,
        ST_POWER_DOWN   = 2'b11
    } power_state_e;

    typedef struct packed {
        logic        ck;
        logic        cke;
        logic        odt;
        logic        cs_n;
        logic        ras_n;
        logic        cas_n;
        logic        we_n;
        logic [2:0]  ba;
        logic [13:0] addr;
        logic        upper_lane_strobe;
        logic        lower_lane_strobe;
    } dram_pins_s;

endpackage

/* File: rtl/dram_dll_switch_freq_change.sv */
// device-side dll mode, self-refresh clock handling and write-leveling feedback with an ahb-lite slave
//
// The implementer's own choices: the register addresses and register access over AHB-Lite.
`timescale 1ns/10ps
module dram_dll_switch_freq_change
    import dram_dll_pkg::*;
(
    input  wire logic        hclk,              // bus and sampling clock
    input  wire logic        hresetn,           // async reset, active low
    input  wire logic        hsel,              // slave select
    input  wire logic [31:0] haddr,             // byte address
    input  wire logic [1:0]  htrans,            // transfer type
    input  wire logic        hwrite,            // write when high
    input  wire logic [2:0]  hsize,             // transfer size, word only
    input  wire logic [31:0] hwdata,            // write data
    input  wire logic        hready,            // bus ready
    output logic      [31:0] hrdata,            // read data
    output logic             hreadyout,         // slave ready
    output logic             hresp,             // always okay
    input  wire dram_pins_s  pins,              // command clock and pins, async
    output logic      [15:0] dq_out,            // data line drive value
    output logic      [15:0] dq_oe,             // data line drive enable
    output logic             dll_off_mode,      // dll switched off
    output logic             write_level_mode,  // leveling active
    output logic      [4:0]  read_launch_cycles // read output delay, strobe and data alike
);

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [4:0] cl_cycles(input logic [13:0] mr0);
        cl_cycles = 5'({2'b00, mr0[MR0_CL_MSB:MR0_CL_LSB]}) + READ_LATENCY_OFFSET;
    endfunction

    // ****************************************
    // pin synchronisers
    // ****************************************
    dram_pins_s   sync1_reg;
    dram_pins_s   sync2_reg;
    logic         ck_prev_reg;
    logic         upper_prev_reg;
    logic         lower_prev_reg;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= pins;
            sync2_reg <= sync1_reg;
        end
    end

    // history resets to the idle low level of each pin, so no false edge follows reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ck_prev_reg    <= 1'b0;
            upper_prev_reg <= 1'b0;
            lower_prev_reg <= 1'b0;
        end else begin
            ck_prev_reg    <= sync2_reg.ck;
            upper_prev_reg <= sync2_reg.upper_lane_strobe;
            lower_prev_reg <= sync2_reg.lower_lane_strobe;
        end
    end

    wire ck_rise    = sync2_reg.ck & ~ck_prev_reg;
    wire upper_rise = sync2_reg.upper_lane_strobe & ~upper_prev_reg;
    wire lower_rise = sync2_reg.lower_lane_strobe & ~lower_prev_reg;

    // ****************************************
    // command decode
    // ****************************************
    wire cmd_nop     = sync2_reg.cs_n | (sync2_reg.ras_n & sync2_reg.cas_n & sync2_reg.we_n);
    wire cmd_mrs     = ~sync2_reg.cs_n & ~sync2_reg.ras_n & ~sync2_reg.cas_n & ~sync2_reg.we_n;
    wire cmd_refresh = ~sync2_reg.cs_n & ~sync2_reg.ras_n & ~sync2_reg.cas_n & sync2_reg.we_n;

    // ****************************************
    // power state
    // ****************************************
    power_state_e state_reg;
    power_state_e state_next;
    logic         cke_prev_reg;
    logic [3:0]   hold_cnt_reg;
    logic [3:0]   hold_cnt_next;

    wire state_active = (state_reg == ST_ACTIVE);
    wire cke_falls    = ck_rise & cke_prev_reg & ~sync2_reg.cke;
    wire hold_done    = ck_rise & (hold_cnt_reg == CLOCK_HOLD_AFTER_SR_ENTRY - 4'h1);

    always_comb begin
        state_next    = state_reg;
        hold_cnt_next = hold_cnt_reg;
        unique case (state_reg)
            ST_ACTIVE: begin
                hold_cnt_next = 4'h0;
                if (cke_falls && cmd_refresh) begin
                    state_next = ST_SELF_REFRESH;
                end else if (cke_falls && cmd_nop) begin
                    state_next = ST_POWER_DOWN;
                end
            end
            ST_SELF_REFRESH: begin
                // exit is asynchronous to the command clock
                if (sync2_reg.cke) begin
                    state_next = ST_ACTIVE;
                end else if (hold_done) begin
                    state_next = ST_SR_CLK_FREE;
                end else if (ck_rise) begin
                    hold_cnt_next = hold_cnt_reg + 4'h1;
                end
            end
            ST_SR_CLK_FREE: begin
                // clock edges are not looked at here; the clock may stop or change rate
                if (sync2_reg.cke) begin
                    state_next = ST_ACTIVE;
                end
            end
            ST_POWER_DOWN: begin
                if (ck_rise && sync2_reg.cke) begin
                    state_next = ST_ACTIVE;
                end
            end
        endcase
    end

    // cke history follows command-clock edges only while the clock matters
    wire cke_prev_next = ck_rise && (state_reg != ST_SR_CLK_FREE) ? sync2_reg.cke : cke_prev_reg;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= ST_ACTIVE;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hold_cnt_reg <= 4'h0;
        end else begin
            hold_cnt_reg <= hold_cnt_next;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cke_prev_reg <= 1'b0;
        end else begin
            cke_prev_reg <= cke_prev_next;
        end
    end

    // ****************************************
    // mode registers
    // ****************************************
    logic [13:0] mode0_reg;
    logic [13:0] mode1_reg;
    logic [13:0] mode2_reg;

    wire mrs_take = ck_rise & state_active & cke_prev_reg & sync2_reg.cke & cmd_mrs;
    wire mode0_wr = mrs_take & (sync2_reg.ba == BANK_MODE0);
    wire mode1_wr = mrs_take & (sync2_reg.ba == BANK_MODE1);
    wire mode2_wr = mrs_take & (sync2_reg.ba == BANK_MODE2);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode0_reg <= MODE_RST;
            mode1_reg <= MODE_RST;
            mode2_reg <= MODE_RST;
        end else begin
            if (mode0_wr) begin
                mode0_reg <= sync2_reg.addr;
            end
            if (mode1_wr) begin
                mode1_reg <= sync2_reg.addr;
            end
            if (mode2_wr) begin
                mode2_reg <= sync2_reg.addr;
            end
        end
    end

    wire dll_off = mode1_reg[MR1_DLL_DISABLE_BIT];
    wire wl_on   = mode1_reg[MR1_WRITE_LEVEL_BIT];

    // only one latency pair is guaranteed with the dll off
    wire latency_ok  = (mode0_reg[MR0_CL_MSB:MR0_CL_LSB] == READ_LATENCY_6_CODE)
                     & ~mode0_reg[MR0_CL_EXT_BIT]
                     & (mode2_reg[MR2_CWL_MSB:MR2_CWL_LSB] == WRITE_LATENCY_6_CODE);
    wire latency_bad = dll_off & ~latency_ok;
    wire dll_reset   = mode0_wr & sync2_reg.addr[MR0_DLL_RESET_BIT] & ~dll_off;

    // the dll-off shift moves strobe and data by the same cycle, keeping their skew
    wire [4:0] launch_next = cl_cycles(mode0_reg) - {4'h0, dll_off};

    // ****************************************
    // write-leveling feedback
    // ****************************************
    logic ctrl_fb_en_reg;
    logic upper_fb_reg;
    logic lower_fb_reg;

    wire        fb_drive = wl_on & ctrl_fb_en_reg;
    // prime bit of each lane carries feedback, the rest held low
    wire [15:0] dq_next  = fb_drive ? {7'h00, upper_fb_reg, 7'h00, lower_fb_reg} : 16'h0000;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            upper_fb_reg <= 1'b0;
            lower_fb_reg <= 1'b0;
        end else begin
            if (wl_on && upper_rise) begin
                upper_fb_reg <= sync2_reg.ck;
            end
            if (wl_on && lower_rise) begin
                lower_fb_reg <= sync2_reg.ck;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dq_out             <= 16'h0000;
            dq_oe              <= 16'h0000;
            read_launch_cycles <= 5'h00;
        end else begin
            dq_out             <= dq_next;
            dq_oe              <= {16{fb_drive}};
            read_launch_cycles <= launch_next;
        end
    end

    assign dll_off_mode     = mode1_reg[MR1_DLL_DISABLE_BIT];
    assign write_level_mode = mode1_reg[MR1_WRITE_LEVEL_BIT];

    // ****************************************
    // ahb-lite slave
    // ****************************************
    logic       wr_pend_reg;
    logic [7:0] wr_addr_reg;
    logic       lat_err_reg;
    logic       dll_reset_reg;

    wire ahb_take  = hsel & htrans[1] & hready;
    wire ctrl_wr   = wr_pend_reg & (wr_addr_reg == ADDR_CTRL);
    wire err_clear = ctrl_wr & hwdata[CTRL_CLEAR_ERR_BIT];

    wire in_sr      = (state_reg == ST_SELF_REFRESH) | (state_reg == ST_SR_CLK_FREE);
    wire in_clk_off = (state_reg == ST_SR_CLK_FREE);
    wire in_pd      = (state_reg == ST_POWER_DOWN);

    logic [31:0] status_word;

    always_comb begin
        status_word                       = 32'h0;
        status_word[STAT_DLL_OFF_BIT]     = dll_off;
        status_word[STAT_WL_MODE_BIT]     = wl_on;
        status_word[STAT_SR_BIT]          = in_sr;
        status_word[STAT_CLK_IGNORED_BIT] = in_clk_off;
        status_word[STAT_PD_BIT]          = in_pd;
        status_word[STAT_LAT_ERR_BIT]     = lat_err_reg;
        status_word[STAT_DLL_RESET_BIT]   = dll_reset_reg;
        status_word[STAT_LOWER_FB_BIT]    = lower_fb_reg;
        status_word[STAT_UPPER_FB_BIT]    = upper_fb_reg;
        status_word[STAT_LAUNCH_LSB +: 5] = read_launch_cycles;
    end

    wire [31:0] rd_word = (haddr[7:0] == ADDR_CTRL)   ? {31'h0, ctrl_fb_en_reg} :
                          (haddr[7:0] == ADDR_STATUS) ? status_word :
                          (haddr[7:0] == ADDR_MODE0)  ? {18'h0, mode0_reg} :
                          (haddr[7:0] == ADDR_MODE1)  ? {18'h0, mode1_reg} :
                          (haddr[7:0] == ADDR_MODE2)  ? {18'h0, mode2_reg} : 32'h0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
            hrdata      <= 32'h0;
            hreadyout   <= 1'b1;
            hresp       <= 1'b0;
        end else begin
            wr_pend_reg <= ahb_take & hwrite;
            if (ahb_take) begin
                wr_addr_reg <= haddr[7:0];
            end
            if (ahb_take && !hwrite) begin
                hrdata <= rd_word;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_fb_en_reg <= CTRL_FEEDBACK_EN_RST;
        end else if (ctrl_wr) begin
            ctrl_fb_en_reg <= hwdata[CTRL_FEEDBACK_EN_BIT];
        end
    end

    // a new event in the clearing cycle wins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lat_err_reg   <= 1'b0;
            dll_reset_reg <= 1'b0;
        end else begin
            lat_err_reg   <= latency_bad | (lat_err_reg & ~err_clear);
            dll_reset_reg <= dll_reset | (dll_reset_reg & ~err_clear);
        end
    end

endmodule

/* File: bench/dram_dll_properties.sv */
// port checks for the dll and leveling block
`timescale 1ns/10ps
module dram_dll_properties
    import dram_dll_pkg::*;
(
    input wire logic        hclk,              // clock
    input wire logic        hresetn,           // reset
    input wire logic        hsel,              // select
    input wire logic [1:0]  htrans,            // type
    input wire logic        hwrite,            // write
    input wire logic        hready,            // ready in
    input wire logic [31:0] hrdata,            // read data
    input wire logic        hreadyout,         // ready out
    input wire logic        hresp,             // response
    input wire dram_pins_s  pins,              // pins
    input wire logic [15:0] dq_out,            // data out
    input wire logic [15:0] dq_oe,             // data enable
    input wire logic        dll_off_mode,      // dll off
    input wire logic        write_level_mode,  // leveling
    input wire logic [4:0]  read_launch_cycles // launch
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_resp_okay: assert property (hreadyout && !hresp)
        else $error("bus answer not ready okay");
    a_rdata_hold: assert property (!(hsel && htrans[1] && hready && !hwrite) |=> $stable(hrdata))
        else $error("read data moved without a read");
    a_launch_off: assert property ($rose(dll_off_mode) |=>
        read_launch_cycles == $past(read_launch_cycles) - 5'h01) else $error("launch not one less");
    a_launch_on: assert property ($fell(dll_off_mode) |=>
        read_launch_cycles == $past(read_launch_cycles) + 5'h01) else $error("launch not one more");
    // cke low long enough means no mode write can be in flight
    a_mode_frozen: assert property ((!pins.cke)[*8] |=>
        $stable(dll_off_mode) && $stable(write_level_mode)) else $error("mode moved with cke low");
    a_oe_idle: assert property (!write_level_mode && !$past(write_level_mode) |->
        dq_oe == 16'h0000 && dq_out == 16'h0000) else $error("data driven outside leveling");
    a_prime_bits: assert property ((dq_out & 16'hfefe) == 16'h0000)
        else $error("feedback off prime bits");
    a_oe_drive: assert property (dq_out != 16'h0000 |-> dq_oe == 16'hffff)
        else $error("feedback without drive");
    a_fb_level: assert property ($rose(dq_out[0]) |-> write_level_mode)
        else $error("feedback outside leveling");
endmodule

/* File: bench/dram_ctrl_model.sv */
// controller-side model driving the memory pins
`timescale 1ns/10ps
module dram_ctrl_model
    import dram_dll_pkg::*;
(
    output dram_pins_s pins // clock, command, strobes
);
    int half; // reloaded by the bench before every rate change
    // odt stays low: termination off around every switch
    initial begin
        pins = '0;
        pins.cs_n = 1'b1;
        half = 160; // changed only in sr or pd by the bench
    end
    // ck rests low between frames; offset keeps it off the bus clock phase
    task automatic cyc(input logic cke, input logic [3:0] cmd, input logic [2:0] ba, input logic [13:0] a);
        begin
            #7;
            {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} = cmd;
            pins.cke = cke; // held high from exit through mode updates
            pins.ba = ba;
            pins.addr = a;
            #half pins.ck = 1'b1;
            #half pins.ck = 1'b0;
            pins.cs_n = 1'b1;
            pins.ba = ~ba;
            pins.addr = ~a;
        end
    endtask
    task automatic lvl(input logic up, input int dly);
        begin
            #7 pins.ck = 1'b1;
            fork
                #160 pins.ck = 1'b0;
                #dly {pins.upper_lane_strobe, pins.lower_lane_strobe} = {up, !up}; // tuned delay
            join
            #160 {pins.upper_lane_strobe, pins.lower_lane_strobe} = 2'b00;
        end
    endtask
endmodule

/* File: bench/tb_top.sv */
// self-checking bench for the dll and leveling block
`timescale 1ns/10ps
module tb_top;
    import dram_dll_pkg::*;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    dram_pins_s  pins;
    logic [15:0] dq_out, dq_oe;
    logic        dll_off_mode, write_level_mode;
    logic [4:0]  read_launch_cycles;
    int          fails, checked, cycles;
    logic [13:0] m0, m1, m2;
    logic        fb_en, sr, ign, pd, le, rs, lfb, ufb;
    dram_dll_switch_freq_change i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .pins, .dq_out, .dq_oe,
        .dll_off_mode, .write_level_mode, .read_launch_cycles);
    dram_ctrl_model i_mc (.pins);
    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            fails++;
            test_done();
        end
    end
    function automatic logic lat_bad();
        lat_bad = m1[0] && !(m0[6:4] == READ_LATENCY_6_CODE && !m0[2] && m2[5:3] == WRITE_LATENCY_6_CODE);
    endfunction
    function automatic logic [31:0] st_exp();
        logic [4:0] l;
        l = 5'(m0[6:4]) + READ_LATENCY_OFFSET - 5'(m1[0]);
        st_exp = {11'h0, l, 7'h0, ufb, lfb, rs, le, pd, ign, sr, m1[7], m1[0]};
    endfunction
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        hsize <= 3'h2;
        haddr <= a;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] d;
        bus(1'b0, a, 32'h0, d);
        chk($sformatf("reg %h", a), exp, d);
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask
    task automatic pchk();
        logic [15:0] oe;
        oe = (m1[7] && fb_en) ? 16'hffff : 16'h0000;
        chk("dll_off_mode", 32'(m1[0]), 32'(dll_off_mode));
        chk("write_level_mode", 32'(m1[7]), 32'(write_level_mode));
        chk("read_launch", st_exp() >> 16, 32'(read_launch_cycles));
        chk("dq_oe", 32'(oe), 32'(dq_oe));
        chk("dq_out", 32'(oe & {7'h0, ufb, 7'h0, lfb}), 32'(dq_out));
    endtask
    task automatic mrs(input logic [2:0] ba, input logic [13:0] a);
        i_mc.cyc(1'b1, 4'h0, ba, a);
        if (ba == BANK_MODE0)
            rs = rs | (a[8] & !m1[0]);
        case (ba)
            BANK_MODE0: m0 = a;
            BANK_MODE1: m1 = a;
            default: m2 = a;
        endcase
        le = le | lat_bad();
        repeat (3) @(posedge hclk);
        pchk();
    endtask
    task automatic nop(input logic cke, input int n);
        repeat (n) i_mc.cyc(cke, 4'h7, 3'h0, 14'h0);
    endtask
    task automatic test_done();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        void'($urandom(74323));
        {hresetn, hsel, haddr, htrans, hsize, hwrite, hwdata} = '0;
        {m0, m1, m2, sr, ign, pd, le, rs, lfb, ufb} = '0;
        fb_en = 1'b1;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        rd(ADDR_CTRL, 32'h1);
        pchk();
        wr(32'h40, $urandom());
        rd(32'h40, 32'h0);
        nop(1'b1, 1);
        mrs(BANK_MODE0, 14'h0020);
        mrs(BANK_MODE2, 14'h0008);
        rd(ADDR_MODE2, 32'h8);
        mrs(BANK_MODE1, 14'h0001);
        rd(ADDR_STATUS, st_exp());
        i_mc.cyc(1'b0, 4'h1, 3'h0, 14'h0);
        sr = 1'b1;
        nop(1'b0, 6);
        ign = 1'b1;
        i_mc.half = 200; // new rate only once the clock is ignored
        nop(1'b0, 2);
        rd(ADDR_STATUS, st_exp());
        nop(1'b1, 1);
        {sr, ign} = 2'b00;
        mrs(BANK_MODE0, 14'h0100 | 14'({$urandom_range(7, 3), 4'h0}));
        rd(ADDR_STATUS, st_exp());
        mrs(BANK_MODE0, 14'h0020);
        wr(ADDR_CTRL, 32'h3);
        le = lat_bad();
        rs = 1'b0;
        rd(ADDR_CTRL, 32'h1);
        mrs(BANK_MODE1, 14'h0000);
        mrs(BANK_MODE0, 14'h0120);
        rd(ADDR_STATUS, st_exp());
        mrs(BANK_MODE2, 14'h0008);
        nop(1'b1, 2);
        nop(1'b0, 1);
        pd = 1'b1;
        rd(ADDR_STATUS, st_exp());
        i_mc.half = 160; // rate change with cke and odt low
        nop(1'b0, 2);
        nop(1'b1, 1);
        pd = 1'b0;
        mrs(BANK_MODE0, 14'h0120);
        mrs(BANK_MODE1, 14'h0080);
        for (int i = 0; i < 4; i++) begin
            i_mc.lvl(i[0], i[1] ? 240 : 80);
            repeat (3) @(posedge hclk);
            if (i[0])
                ufb = !i[1];
            else
                lfb = !i[1];
            pchk();
        end
        rd(ADDR_STATUS, st_exp());
        wr(ADDR_CTRL, 32'h0);
        fb_en = 1'b0;
        repeat (2) @(posedge hclk);
        pchk();
        mrs(BANK_MODE1, 14'h0000);
        test_done();
    end
endmodule
bind dram_dll_switch_freq_change dram_dll_properties i_props (.hclk, .hresetn, .hsel, .htrans, .hwrite,
    .hready, .hrdata, .hreadyout, .hresp, .pins, .dq_out, .dq_oe, .dll_off_mode, .write_level_mode,
    .read_launch_cycles);
